// ==== shared/mia_pkg.sv ====
// Package: register indices, field layout, reset values and carrier types of the MMD indirect access block
package mia_pkg;

  // Register indices on the management register port
  localparam logic [4:0]  MIA_IDX_CTRL       = 5'h0D;
  localparam logic [4:0]  MIA_IDX_DATA       = 5'h0E;
  localparam logic [4:0]  MIA_IDX_EXT_STATUS = 5'h0F;

  // Control register field positions
  localparam int          MIA_MODE_HI        = 15;
  localparam int          MIA_MODE_LO        = 14;
  localparam int          MIA_RSVD_HI        = 13;
  localparam int          MIA_RSVD_LO        = 5;
  localparam int          MIA_DEVAD_HI       = 4;
  localparam int          MIA_DEVAD_LO       = 0;

  // Operation mode encodings
  localparam logic [1:0]  MIA_MODE_REGISTER  = 2'h0;
  localparam logic [1:0]  MIA_MODE_NO_INC    = 2'h1;
  localparam logic [1:0]  MIA_MODE_INC_RW    = 2'h2;
  localparam logic [1:0]  MIA_MODE_INC_WR    = 2'h3;

  // Reset values
  localparam logic [1:0]  MIA_MODE_RST       = 2'h0;
  localparam logic [8:0]  MIA_RSVD_RST       = 9'h000;
  localparam logic [4:0]  MIA_DEVAD_RST      = 5'h00;
  localparam logic [15:0] MIA_ADDR_RST       = 16'h0000;

  // Extended status: 1000X FD/HD clear, 1000T FD/HD set, low bits zero
  localparam logic [15:0] MIA_EXT_STATUS     = 16'h3000;

  // Management request: one register access
  typedef struct packed {
    logic        write;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mia_req_type;

  // Access toward the MMD register space
  typedef struct packed {
    logic        write;
    logic [4:0]  devad;
    logic [15:0] regaddr;
    logic [15:0] wdata;
  } mia_mmd_type;

endpackage

// ==== design/mia_addr_ptr.sv ====
// Stored MMD register address with load and post-increment
`timescale 1ns/10ps
`default_nettype none

module mia_addr_ptr
  import mia_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        inc_i,
  // State
  output logic      [15:0] addr_o
);

  // Load wins over increment; the owner never asks for both at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o <= MIA_ADDR_RST;
    end else if (load_i) begin
      addr_o <= load_val_i;
    end else if (inc_i) begin
      addr_o <= 16'(addr_o + 16'h0001); // RULE11
    end
  end

endmodule

`default_nettype wire

// ==== design/mia_regs.sv ====
// MMD indirect access control, register/data window and extended status registers
// Functional notes
// RULE1: Two-bit operation mode in control bits 15:14, resets to 00, steers data window.
// RULE2: Mode 01 moves data at stored address and leaves the address unchanged.
// RULE3: Mode 10 moves data and advances the address after every read and write.
// RULE4: Mode 11 advances the address after writes only; reads leave it unchanged.
// RULE5: Control bits 4:0 hold the read/write MMD device address, reset zero.
// RULE6: Mode 00 makes the window the register address: writes load it, reads return it.
// RULE7: Data modes route window reads and writes to the selected device and address.
// RULE8: Extended status reports 1000Base-X full and half duplex unsupported, reading zero.
// RULE9: Extended status reports 1000Base-T full and half duplex supported, reading one.
// RULE10: Host sets device and mode 00, writes address, then selects a data mode.
// RULE11: Post-increment adds one modulo 65536 right after the triggering access.
`timescale 1ns/10ps
`default_nettype none

module mia_regs
  import mia_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Management register port
  input  wire logic        req_valid_i,
  input  wire mia_req_type req_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic      [15:0] rsp_rdata_o,
  // MMD register space
  output logic             mmd_strobe_o,
  output mia_mmd_type      mmd_o,
  input  wire logic [15:0] mmd_rdata_i
);

  logic        rst_meta;
  logic        rst_n;
  logic        pend;
  mia_req_type req_q;
  logic [1:0]  mode;
  logic [8:0]  ctrl_rsvd;
  logic [4:0]  devad;
  logic [15:0] reg_addr;
  logic        take;
  logic        ctrl_wr;
  logic        addr_load;
  logic        data_acc;
  logic        post_inc;
  logic [15:0] next_rdata;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // One access in flight; the second cycle finishes it, so ready drops for one cycle
  assign req_ready_o = ~pend;
  assign take        = req_valid_i & ~pend;
  assign ctrl_wr     = take & req_i.write & (req_i.addr == MIA_IDX_CTRL);
  assign addr_load   = take & req_i.write & (req_i.addr == MIA_IDX_DATA) & (mode == MIA_MODE_REGISTER); // RULE6
  assign data_acc    = pend & (req_q.addr == MIA_IDX_DATA) & (mode != MIA_MODE_REGISTER); // RULE7

  // Increment choice per mode
  always_comb begin
    case (mode)
      MIA_MODE_NO_INC:  post_inc = 1'b0;                      // RULE2
      MIA_MODE_INC_RW:  post_inc = data_acc;                  // RULE3
      MIA_MODE_INC_WR:  post_inc = data_acc & req_q.write;    // RULE4
      default:          post_inc = 1'b0;
    endcase
  end

  // Request capture
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend  <= 1'b0;
      req_q <= '0;
    end else begin
      pend <= take;
      if (take) begin
        req_q <= req_i;
      end
    end
  end

  // Control register; mode only changes on an accepted write, never mid-access
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= MIA_MODE_RST;
      ctrl_rsvd <= MIA_RSVD_RST;
      devad     <= MIA_DEVAD_RST;
    end else if (ctrl_wr) begin
      mode      <= req_i.wdata[MIA_MODE_HI:MIA_MODE_LO];    // RULE1
      ctrl_rsvd <= req_i.wdata[MIA_RSVD_HI:MIA_RSVD_LO];
      devad     <= req_i.wdata[MIA_DEVAD_HI:MIA_DEVAD_LO];  // RULE5
    end
  end

  // Stored MMD register address
  mia_addr_ptr u_addr_ptr (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_n),
    .load_i     (addr_load),
    .load_val_i (req_i.wdata),
    .inc_i      (post_inc),      // RULE11
    .addr_o     (reg_addr)
  );

  // MMD access launched in the cycle after acceptance, from registered fields
  assign mmd_strobe_o  = data_acc;
  assign mmd_o.write   = req_q.write;
  assign mmd_o.devad   = devad;      // RULE7
  assign mmd_o.regaddr = reg_addr;
  assign mmd_o.wdata   = req_q.wdata;

  // Read data select; unmapped indices read zero, since neighbouring registers live elsewhere
  always_comb begin
    next_rdata = 16'h0000;
    case (req_q.addr)
      MIA_IDX_CTRL:       next_rdata = {mode, ctrl_rsvd, devad};
      MIA_IDX_DATA:       next_rdata = (mode == MIA_MODE_REGISTER) ? reg_addr : mmd_rdata_i; // RULE6 RULE7
      MIA_IDX_EXT_STATUS: next_rdata = MIA_EXT_STATUS;  // RULE8 RULE9
      default:            next_rdata = 16'h0000;
    endcase
  end

  // Response two cycles after acceptance, for reads and writes alike
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 16'h0000;
    end else begin
      rsp_valid_o <= pend;
      if (pend) begin
        rsp_rdata_o <= req_q.write ? 16'h0000 : next_rdata;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  logic [15:0] wdata_now;
  logic        rd_data_take;
  logic        rd_ext_take;
  assign wdata_now    = req_i.wdata;
  assign rd_data_take = take & ~req_i.write & (req_i.addr == MIA_IDX_DATA) & (mode != MIA_MODE_REGISTER);
  assign rd_ext_take  = take & ~req_i.write & (req_i.addr == MIA_IDX_EXT_STATUS);

  sequence s_data_read;
    rd_data_take ##1 mmd_strobe_o;
  endsequence

  sequence s_ext_read;
    rd_ext_take ##1 pend;
  endsequence

  a_mode_update: assert property (ctrl_wr |=> mode == $past(wdata_now[15:14])) // RULE1
    else $error("mode field not loaded by control write");
  a_nopost_hold: assert property (data_acc && mode == MIA_MODE_NO_INC |=> reg_addr == $past(reg_addr)) // RULE2
    else $error("address moved in no-increment mode");
  a_postinc_rw: assert property (data_acc && mode == MIA_MODE_INC_RW |=> reg_addr == 16'($past(reg_addr) + 16'h0001)) // RULE3
    else $error("address not advanced after data access");
  a_postinc_wr: assert property (data_acc && mode == MIA_MODE_INC_WR |=>
      reg_addr == ($past(req_q.write) ? 16'($past(reg_addr) + 16'h0001) : $past(reg_addr))) // RULE4
    else $error("write-only increment wrong");
  a_devad_load: assert property (ctrl_wr |=> devad == $past(wdata_now[4:0])) // RULE5
    else $error("device address not loaded");
  a_regaddr_load: assert property (addr_load |=> reg_addr == $past(wdata_now) ##1 rsp_valid_o) // RULE6
    else $error("register address not loaded");
  a_data_route: assert property (s_data_read |-> mmd_o.devad == devad && !mmd_o.write
      ##1 rsp_valid_o && rsp_rdata_o == $past(mmd_rdata_i)) // RULE7
    else $error("data read not routed to MMD space");
  a_ext_status: assert property (s_ext_read |=> rsp_valid_o && rsp_rdata_o[15:12] == 4'h3) // RULE8 RULE9
    else $error("extended status bits wrong");
  a_no_addr_idle: assert property (!pend && !addr_load |=> reg_addr == $past(reg_addr)) // RULE11
    else $error("address moved without an access");

endmodule

`default_nettype wire

// ==== verif/mia_mmd_model.sv ====
// Behavioural MMD register space behind the indirect window
`timescale 1ns/10ps
`default_nettype none
module mia_mmd_model
  import mia_pkg::*;
(
  // Clock
  input  wire logic        core_clk_i,
  // Access from the window
  input  wire logic        mmd_strobe_i,
  input  wire mia_mmd_type mmd_i,
  output logic      [15:0] mmd_rdata_o
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] last = 16'h0000;
  // Writes land at the edge ending the strobe cycle
  always @(posedge core_clk_i) begin
    if (mmd_strobe_i) begin
      if (mmd_i.write) mem[{mmd_i.devad, mmd_i.regaddr}] = mmd_i.wdata;
      last = mmd_rdata_o;
    end
  end
  // Unwritten places read as the inverted address; idle bus shows inverted last value
  always @* begin
    if (!mmd_strobe_i) mmd_rdata_o = ~last;
    else if (mem.exists({mmd_i.devad, mmd_i.regaddr})) mmd_rdata_o = mem[{mmd_i.devad, mmd_i.regaddr}];
    else mmd_rdata_o = ~mmd_i.regaddr;
  end
endmodule
`default_nettype wire

// ==== verif/test_mia_regs.sv ====
// Self-checking bench for the MMD indirect access registers
`timescale 1ns/10ps
`default_nettype none
module test_mia_regs;
  import mia_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        req_valid_i = 1'b0;
  mia_req_type req_i = '0;
  logic        req_ready_o, rsp_valid_o, mmd_strobe_o;
  logic [15:0] rsp_rdata_o, mmd_rdata_i, q, a;
  mia_mmd_type mmd_o;
  logic [1:0]  m;
  logic [4:0]  dv;
  logic [15:0] d;
  logic        w;
  logic [15:0] ref_mem [logic [20:0]];
  int          errors = 0;
  int          n_compared = 0;
  mia_regs dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .mmd_strobe_o(mmd_strobe_o), .mmd_o(mmd_o), .mmd_rdata_i(mmd_rdata_i));
  mia_mmd_model mmd (.core_clk_i(core_clk_i), .mmd_strobe_i(mmd_strobe_o), .mmd_i(mmd_o),
    .mmd_rdata_o(mmd_rdata_i));
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One register access; inputs move only at falling edges, waits are bounded
  task automatic acc(input logic wr, input logic [4:0] ad, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(negedge core_clk_i);
    req_valid_i = 1'b1;
    req_i = '{write: wr, addr: ad, wdata: wd};
    n = 0;
    while (req_ready_o !== 1'b1 && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    @(negedge core_clk_i);
    check(16'(req_ready_o), 16'h0000);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 8) begin
      errors++;
      summarize();
    end else begin
      rd = rsp_rdata_o;
    end
  endtask
  // Address after a data access in mode md
  function automatic logic [15:0] next_addr(input logic [1:0] md, input logic wr, input logic [15:0] ad);
    if (md == MIA_MODE_INC_RW || (md == MIA_MODE_INC_WR && wr)) return ad + 16'h0001;
    return ad;
  endfunction
  initial begin
    void'($urandom(32'h1dd351c8));
    repeat (5) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    acc(1'b0, MIA_IDX_CTRL, 16'h0000, q); check(q, 16'h0000);
    acc(1'b0, MIA_IDX_DATA, 16'h0000, q); check(q, MIA_ADDR_RST);
    acc(1'b1, MIA_IDX_EXT_STATUS, 16'hFFFF, q);
    acc(1'b0, MIA_IDX_EXT_STATUS, 16'h0000, q); check(q & 16'hC000, 16'h0000);
    check(q & 16'h3000, 16'h3000);
    acc(1'b0, 5'h10, 16'h0000, q); check(q, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      dv = 5'($urandom);
      m = (i < 3) ? 2'(i + 1) : 2'($urandom_range(3, 1));
      a = (i % 4 == 1) ? 16'hFFFE : 16'($urandom);
      // Host order: device with register mode, then address, then a data mode
      acc(1'b1, MIA_IDX_CTRL, {MIA_MODE_REGISTER, 9'h000, dv}, q);
      acc(1'b1, MIA_IDX_DATA, a, q);
      acc(1'b0, MIA_IDX_DATA, 16'h0000, q); check(q, a);
      acc(1'b1, MIA_IDX_CTRL, {m, 9'h000, dv}, q);
      acc(1'b0, MIA_IDX_CTRL, 16'h0000, q); check(q, {m, 9'h000, dv});
      repeat (3) begin
        w = 1'($urandom);
        d = 16'($urandom);
        acc(w, MIA_IDX_DATA, d, q);
        if (w) ref_mem[{dv, a}] = d;
        else check(q, ref_mem.exists({dv, a}) ? ref_mem[{dv, a}] : ~a);
        a = next_addr(m, w, a);
      end
      acc(1'b1, MIA_IDX_CTRL, {MIA_MODE_REGISTER, 9'h000, dv}, q);
      acc(1'b0, MIA_IDX_DATA, 16'h0000, q); check(q, a);
    end
    // Mid-run reset must bring control, reserved bits and stored address back to defaults
    acc(1'b1, MIA_IDX_CTRL, 16'h3FFF, q);
    @(negedge core_clk_i);
    reset_n_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    acc(1'b0, MIA_IDX_CTRL, 16'h0000, q); check(q, 16'h0000);
    acc(1'b0, MIA_IDX_DATA, 16'h0000, q); check(q, MIA_ADDR_RST);
    summarize();
  end
endmodule
`default_nettype wire
